/* include/supply_map.svh */
// Register map, field positions, reset values and timing constants of the supply control block
`ifndef SUPPLY_MAP_SVH
`define SUPPLY_MAP_SVH

// Register offsets
`define FLAGS_OFFSET            8'h1D
`define CONTROL_OFFSET          8'h1F

// Flag register fields
`define FLAG_BACKUP_LOW_BIT     7
`define FLAG_RESET_DROP_BIT     2
`define FLAG_FULL_CHARGE_BIT    0

// Control register fields
`define CTRL_SAMPLE_HI_BIT      7
`define CTRL_SAMPLE_LO_BIT      6
`define CTRL_CHARGE_EN_BIT      5
`define CTRL_INIT_BIT           4
`define CTRL_RESET_SEL_BIT      2
`define CTRL_FULL_SEL_HI_BIT    1
`define CTRL_FULL_SEL_LO_BIT    0
`define CONTROL_RESET_VALUE     8'h00
`define FULL_SEL_OFF            2'h3

// Timing, in microseconds, and the clock rate
`define CLK_FREQ_MHZ            250
`define WINDOW_2MS_US           2000
`define WINDOW_16MS_US          16000
`define WINDOW_128MS_US         128000
`define WINDOW_256MS_US         256000
`define PERIOD_MAIN_US          1000000
`define PERIOD_BACKUP_US        125000

`endif

/* include/supply_pkg.sv */
// Types shared by the supply switchover and reset control block
package supply_pkg;

    typedef enum logic [1:0] {
        ST_WAIT_MAIN,
        ST_MAIN,
        ST_BACKUP
    } power_state_type;

    typedef logic [7:0] reg_byte_type;

endpackage

/* verilog/detector_sync.sv */
// Two-flop synchroniser for a group of comparator outputs
`timescale 1ns/1ps
module detector_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // One pair of flops per comparator bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule

/* verilog/backup_switchover_reset_control.sv */
// Supply switchover, backup charge, detector duty cycle, reset output and status flags
//
// Functional notes
// - Charge enable clear keeps charge path open; set gives automatic switch control.
// - Once init written 1, switchover is automatic even with charge enable clear.
// - Init, once set, stays in force; writing 0 later does not undo it.
// - With init set, host interface halts while main supply is below reset level.
// - On move to backup, switches block any current from backup into main.
// - Backup before main: both switches off, nothing runs until main appears.
// - First main power-on: switch two off, one on; no charge until control written.
// - Primary cell: two off, one on with main; two on, one off without.
// - Charging with full detect: both on, full opens two, loss selects two only.
// - Full detect off: both on under main, switch one opens on main loss.
// - Detector active window 2, 16, 128 or 256 ms chosen by sample time.
// - Sampling every 1 s on main, 125 ms on backup; backup window capped 16 ms.
// - During each active window the switch between supply pins is opened.
// - Switchover detector watched continuously on main, whatever the duty setting.
// - Full-charge and over-discharge detectors share the same duty-cycle setting.
// - Full level 00 3.02 V, 01 3.08 V, 10 2.92 V, 11 never stop.
// - Full-charge flag is read-only and reads 1 while backup is full; held 0 off main supply, with charge enable clear or level 11.
// - Backup-low flag set on drop, held until written 0; writing 1 ignored.
// - Reset output released above reset level, asserted on main drop.
// - Reset level select 0 gives 2.75 V, 1 gives 2.7 V falling threshold.
// - Reset-drop flag set on reset-level drop, held until written 0.
`timescale 1ns/1ps
`include "supply_map.svh"
module backup_switchover_reset_control
    import supply_pkg::*;
#(
    parameter int WIN0_CYC        = `WINDOW_2MS_US * `CLK_FREQ_MHZ,
    parameter int WIN1_CYC        = `WINDOW_16MS_US * `CLK_FREQ_MHZ,
    parameter int WIN2_CYC        = `WINDOW_128MS_US * `CLK_FREQ_MHZ,
    parameter int WIN3_CYC        = `WINDOW_256MS_US * `CLK_FREQ_MHZ,
    parameter int PERIOD_MAIN_CYC = `PERIOD_MAIN_US * `CLK_FREQ_MHZ,
    parameter int PERIOD_BACK_CYC = `PERIOD_BACKUP_US * `CLK_FREQ_MHZ,
    parameter int CNT_W           = 28
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         reg_write,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    output logic      [7:0]   reg_rdata,
    input  wire logic         switchover_detector,
    input  wire logic         reset_level_detector,
    input  wire logic         full_charge_detector,
    input  wire logic         backup_low_detector,
    output logic              switch_one,
    output logic              switch_two,
    output logic              detector_active,
    output logic [1:0]        full_charge_level_select,
    output logic              full_charge_stop_off,
    output logic              reset_level_select,
    output logic              host_if_halt,
    input  wire logic         reset_output_n_i,
    output logic              reset_output_n_o,
    output logic              reset_output_n_oe
);

    logic [3:0]       det_sync;
    logic             main_ok;
    logic             reset_ok;
    logic             full_det;
    logic             low_det;
    logic             reset_ok_d_reg;
    power_state_type  state_reg;
    power_state_type  state_next;
    logic [1:0]       sample_sel_reg;
    logic             charge_enable_reg;
    logic             init_written_reg;
    logic             init_latched_reg;
    logic             reset_sel_reg;
    logic [1:0]       full_sel_reg;
    logic             full_charge_flag_reg;
    logic             backup_low_flag_reg;
    logic             reset_drop_flag_reg;
    logic [CNT_W-1:0] period_cnt_reg;
    logic [CNT_W-1:0] period_len;
    logic [CNT_W-1:0] window_len;
    logic             window_on;
    logic             window_end;
    logic             automatic_ctrl;
    logic             sw_one_next;
    logic             sw_two_next;
    logic             flags_write;
    logic             ctrl_write;
    logic             backup_low_event;
    logic             reset_drop_event;

    // Comparators cross into the clock domain here
    detector_sync #(
        .WIDTH (4)
    ) i_detector_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({backup_low_detector, full_charge_detector, reset_level_detector, switchover_detector}),
        .sync_out (det_sync)
    );

    assign main_ok  = det_sync[0];
    assign reset_ok = det_sync[1];
    assign full_det = det_sync[2];
    assign low_det  = det_sync[3];

    // Register write strobes
    assign flags_write = reg_write && (reg_addr == `FLAGS_OFFSET);
    assign ctrl_write  = reg_write && (reg_addr == `CONTROL_OFFSET);

    // Control register fields
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sample_sel_reg    <= 2'h0;
            charge_enable_reg <= 1'b0;
            init_written_reg  <= 1'b0;
            reset_sel_reg     <= 1'b0;
            full_sel_reg      <= 2'h0;
        end else if (ctrl_write) begin
            sample_sel_reg    <= reg_wdata[`CTRL_SAMPLE_HI_BIT:`CTRL_SAMPLE_LO_BIT];
            charge_enable_reg <= reg_wdata[`CTRL_CHARGE_EN_BIT];
            init_written_reg  <= reg_wdata[`CTRL_INIT_BIT];
            reset_sel_reg     <= reg_wdata[`CTRL_RESET_SEL_BIT];
            full_sel_reg      <= reg_wdata[`CTRL_FULL_SEL_HI_BIT:`CTRL_FULL_SEL_LO_BIT];
        end
    end

    // Initialised state is sticky once set
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_latched_reg <= 1'b0;
        end else if (ctrl_write && reg_wdata[`CTRL_INIT_BIT]) begin
            init_latched_reg <= 1'b1;
        end
    end

    // Automatic switching from charge enable or the latched init
    assign automatic_ctrl = charge_enable_reg || init_latched_reg;

    // Supply state: wait for main, main operation, backup operation
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_WAIT_MAIN: begin
                if (main_ok) begin
                    state_next = ST_MAIN;
                end
            end
            ST_MAIN: begin
                if (!main_ok) begin
                    state_next = ST_BACKUP;
                end
            end
            ST_BACKUP: begin
                if (main_ok) begin
                    state_next = ST_MAIN;
                end
            end
            default: begin
                state_next = ST_WAIT_MAIN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_WAIT_MAIN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Sampling period and active window length
    always_comb begin
        period_len = (state_reg == ST_BACKUP) ? CNT_W'(PERIOD_BACK_CYC) : CNT_W'(PERIOD_MAIN_CYC);
        unique case (sample_sel_reg)
            2'h0: window_len = CNT_W'(WIN0_CYC);
            2'h1: window_len = CNT_W'(WIN1_CYC);
            2'h2: window_len = CNT_W'(WIN2_CYC);
            2'h3: window_len = CNT_W'(WIN3_CYC);
        endcase
        if (state_reg == ST_BACKUP && sample_sel_reg[1]) begin
            window_len = CNT_W'(WIN1_CYC);
        end
    end

    assign window_on  = (state_reg != ST_WAIT_MAIN) && (period_cnt_reg < window_len);
    assign window_end = (state_reg != ST_WAIT_MAIN) && (period_cnt_reg == window_len - CNT_W'(1));

    // Period counter restarts on every supply state change
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            period_cnt_reg <= '0;
        end else if (state_next != state_reg || period_cnt_reg >= period_len - CNT_W'(1)) begin
            period_cnt_reg <= '0;
        end else begin
            period_cnt_reg <= period_cnt_reg + CNT_W'(1);
        end
    end

    // Both duty-cycled detectors share the same window
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            detector_active <= 1'b0;
        end else begin
            detector_active <= window_on;
        end
    end

    // Switch selection by supply state and control bits
    always_comb begin
        sw_one_next = 1'b0;
        sw_two_next = 1'b0;
        unique case (state_reg)
            ST_WAIT_MAIN: begin
                sw_one_next = 1'b0;
                sw_two_next = 1'b0;
            end
            ST_MAIN: begin
                sw_one_next = 1'b1;
                if (!automatic_ctrl || !charge_enable_reg) begin
                    sw_two_next = 1'b0;
                end else if (full_sel_reg == `FULL_SEL_OFF) begin
                    sw_two_next = 1'b1;
                end else begin
                    sw_two_next = !full_charge_flag_reg;
                end
                if (window_on) begin
                    sw_two_next = 1'b0;
                end
            end
            ST_BACKUP: begin
                sw_one_next = 1'b0;
                sw_two_next = automatic_ctrl && !window_on;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            switch_one <= 1'b0;
            switch_two <= 1'b0;
        end else begin
            switch_one <= sw_one_next;
            switch_two <= sw_two_next;
        end
    end

    // Threshold selects driven to the comparators
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            full_charge_level_select <= 2'h0;
            full_charge_stop_off     <= 1'b0;
            reset_level_select       <= 1'b0;
        end else begin
            full_charge_level_select <= full_sel_reg;
            full_charge_stop_off     <= (full_sel_reg == `FULL_SEL_OFF);
            reset_level_select       <= reset_sel_reg;
        end
    end

    // Full-charge status sampled at the end of each main window
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            full_charge_flag_reg <= 1'b0;
        end else if (state_reg != ST_MAIN || full_sel_reg == `FULL_SEL_OFF || !charge_enable_reg) begin
            full_charge_flag_reg <= 1'b0;
        end else if (window_end) begin
            full_charge_flag_reg <= full_det;
        end
    end

    // Sticky drop events
    assign backup_low_event = window_end && low_det;
    assign reset_drop_event = reset_ok_d_reg && !reset_ok;

    // Backup-low flag, set wins over a write of 0
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            backup_low_flag_reg <= 1'b0;
        end else if (backup_low_event) begin
            backup_low_flag_reg <= 1'b1;
        end else if (flags_write && !reg_wdata[`FLAG_BACKUP_LOW_BIT]) begin
            backup_low_flag_reg <= 1'b0;
        end
    end

    // Reset-drop flag with its edge delay; set wins over a write of 0
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reset_ok_d_reg      <= 1'b0;
            reset_drop_flag_reg <= 1'b0;
        end else begin
            reset_ok_d_reg <= reset_ok;
            if (reset_drop_event) begin
                reset_drop_flag_reg <= 1'b1;
            end else if (flags_write && !reg_wdata[`FLAG_RESET_DROP_BIT]) begin
                reset_drop_flag_reg <= 1'b0;
            end
        end
    end

    // Open-drain reset pin follows the reset level; host interface halt follows it only once init is latched
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reset_output_n_o  <= 1'b0;
            reset_output_n_oe <= 1'b1;
            host_if_halt      <= 1'b0;
        end else begin
            reset_output_n_o  <= 1'b0;
            reset_output_n_oe <= !reset_ok;
            host_if_halt      <= init_latched_reg && !reset_ok;
        end
    end

    // Registered read data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr == `FLAGS_OFFSET) begin
            reg_rdata <= {backup_low_flag_reg, 4'h0, reset_drop_flag_reg, 1'b0, full_charge_flag_reg};
        end else if (reg_addr == `CONTROL_OFFSET) begin
            reg_rdata <= {sample_sel_reg, charge_enable_reg, init_written_reg, 1'b0, reset_sel_reg, full_sel_reg};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Checks
    AST_CHARGE_OFF: assert property (@(posedge clk) disable iff (reset)
        (!automatic_ctrl) |=> !switch_two)
        else $error("Charge path closed without automatic control");
    AST_INIT_SWITCHOVER: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_BACKUP && init_latched_reg && !window_on) |=> (switch_two && !switch_one))
        else $error("Initialised switchover did not select backup");
    AST_INIT_STICKY: assert property (@(posedge clk) disable iff (reset)
        init_latched_reg |=> init_latched_reg)
        else $error("Initialised state was lost");
    AST_HOST_HALT: assert property (@(posedge clk) disable iff (reset)
        (init_latched_reg && !reset_ok) |=> host_if_halt)
        else $error("Host interface not halted on drop");
    AST_WAIT_OFF: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_WAIT_MAIN) |=> (!switch_one && !switch_two))
        else $error("Switches closed before main supply");
    AST_BACKUP_WINDOW: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_BACKUP && window_on) |-> (period_cnt_reg < CNT_W'(WIN1_CYC)))
        else $error("Backup window longer than the cap");
    AST_WINDOW_OPEN: assert property (@(posedge clk) disable iff (reset)
        window_on |=> !switch_two)
        else $error("Supply switch closed during detection window");
    AST_SWITCHOVER: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_MAIN && !main_ok) |=> (state_reg == ST_BACKUP) ##1 !switch_one)
        else $error("Main drop not followed by backup selection");
    AST_LOW_FLAG: assert property (@(posedge clk) disable iff (reset)
        backup_low_event |=> (backup_low_flag_reg and (!flags_write |=> backup_low_flag_reg)))
        else $error("Backup-low flag missed or cleared too soon");
    AST_RESET_PIN: assert property (@(posedge clk) disable iff (reset)
        (!reset_ok) |=> (reset_output_n_oe && !reset_output_n_o))
        else $error("Reset output not driven low on drop");
    AST_DROP_FLAG: assert property (@(posedge clk) disable iff (reset)
        (reset_ok_d_reg && !reset_ok) |=> reset_drop_flag_reg)
        else $error("Reset-drop flag not set");

endmodule

/* bench/supply_model.sv */
// Analogue far side: main supply, backup element, comparators and reset pull-up
`timescale 1ns/1ps
module supply_model (
    input  wire logic [15:0] main_mv,
    input  wire logic [15:0] backup_mv,
    input  wire logic [1:0]  full_charge_level_select,
    input  wire logic        full_charge_stop_off,
    input  wire logic        reset_level_select,
    input  wire logic        reset_output_n_o,
    input  wire logic        reset_output_n_oe,
    output logic             switchover_detector,
    output logic             reset_level_detector,
    output logic             full_charge_detector,
    output logic             backup_low_detector,
    output logic             reset_output_n
);
    // Thresholds in millivolts
    localparam logic [15:0] SWITCHOVER_MV = 16'h0546;
    localparam logic [15:0] RESET_HI_MV   = 16'h0ABE;
    localparam logic [15:0] RESET_LO_MV   = 16'h0A8C;
    localparam logic [15:0] FULL_00_MV    = 16'h0BCC;
    localparam logic [15:0] FULL_01_MV    = 16'h0C08;
    localparam logic [15:0] FULL_10_MV    = 16'h0B68;
    localparam logic [15:0] LOW_MV        = 16'h0960;

    logic [15:0] full_mv;

    // Full level picked from the select lines
    always_comb begin
        case (full_charge_level_select)
            2'h0: full_mv = FULL_00_MV;
            2'h1: full_mv = FULL_01_MV;
            default: full_mv = FULL_10_MV;
        endcase
    end

    // Comparator outputs
    assign switchover_detector  = main_mv >= SWITCHOVER_MV;
    assign reset_level_detector = main_mv >= (reset_level_select ? RESET_LO_MV : RESET_HI_MV);
    assign full_charge_detector = !full_charge_stop_off && (backup_mv >= full_mv);
    assign backup_low_detector  = backup_mv < LOW_MV;

    // Open-drain pin with pull-up
    assign reset_output_n = reset_output_n_oe ? reset_output_n_o : 1'b1;
endmodule

/* bench/backup_switchover_reset_control_test.sv */
// Self-checking bench for the supply switchover and reset control block
`timescale 1ns/1ps
module backup_switchover_reset_control_test;
    import supply_pkg::*;
    localparam logic [7:0] W0 = 8'h04;
    localparam logic [7:0] W1 = 8'h08;
    localparam logic [7:0] W2 = 8'h0C;
    localparam logic [7:0] W3 = 8'h10;
    localparam int         PM = 64;
    localparam int         PB = 32;

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        reg_write = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [15:0] main_mv = 16'h0000;
    logic [15:0] backup_mv = 16'h0BB8;
    logic        sod, rld, fcd, bld, switch_one, switch_two, detector_active, stop_off, rsel, host_if_halt;
    logic        rst_o, rst_oe, rst_pin;
    logic [1:0]  fsel;
    logic [7:0]  rv;
    int          errors = 0;
    int          checked = 0;

    // Clock, 4 ns period
    always #2 clk = ~clk;

    backup_switchover_reset_control #(.WIN0_CYC(W0), .WIN1_CYC(W1), .WIN2_CYC(W2), .WIN3_CYC(W3),
        .PERIOD_MAIN_CYC(PM), .PERIOD_BACK_CYC(PB)) i_backup_switchover_reset_control (
        .clk(clk), .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .switchover_detector(sod), .reset_level_detector(rld),
        .full_charge_detector(fcd), .backup_low_detector(bld), .switch_one(switch_one),
        .switch_two(switch_two), .detector_active(detector_active), .full_charge_level_select(fsel),
        .full_charge_stop_off(stop_off), .reset_level_select(rsel), .host_if_halt(host_if_halt),
        .reset_output_n_i(rst_pin), .reset_output_n_o(rst_o), .reset_output_n_oe(rst_oe));

    supply_model i_supply_model (
        .main_mv(main_mv), .backup_mv(backup_mv), .full_charge_level_select(fsel),
        .full_charge_stop_off(stop_off), .reset_level_select(rsel), .reset_output_n_o(rst_o),
        .reset_output_n_oe(rst_oe), .switchover_detector(sod), .reset_level_detector(rld),
        .full_charge_detector(fcd), .backup_low_detector(bld), .reset_output_n(rst_pin));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_write = 1'b0;
    endtask

    // Registered read, data one cycle after address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask

    // Covers synchroniser and state latency
    task automatic settle;
        repeat (10) @(negedge clk);
    endtask

    // Wait until outside a detector window
    task automatic wait_idle;
        int n;
        n = 0;
        for (int i = 0; i < 400 && n < 2; i++) begin
            @(negedge clk);
            if (detector_active === 1'b0) n++;
            else n = 0;
        end
    endtask

    // Active cycles over a span; switch two must be open in them
    task automatic cnt(input int len, input logic [7:0] exp);
        logic [7:0] act;
        logic [7:0] clash;
        act = 8'h00;
        clash = 8'h00;
        repeat (len) begin
            @(negedge clk);
            if (detector_active === 1'b1) act++;
            if (detector_active === 1'b1 && switch_two !== 1'b0) clash++;
        end
        chk(act, exp);
        chk(clash, 8'h00);
    endtask

    // Final verdict
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish;
    end

    // Test sequence
    initial begin
        repeat (10) @(negedge clk);
        reset = 1'b0;
        settle;
        chk({switch_two, switch_one}, 8'h00);
        chk(rst_pin, 8'h00);
        rd(8'h1F, 8'h00);
        rd(8'h1D, 8'h00);
        $display("end of test: backup first");
        main_mv = 16'h0CE4;
        settle;
        chk({switch_two, switch_one}, 8'h01);
        chk(rst_pin, 8'h01);
        main_mv = 16'h0000;
        settle;
        chk({switch_two, switch_one}, 8'h00);
        rd(8'h1D, 8'h04);
        wr(8'h1D, 8'hFF);
        rd(8'h1D, 8'h04);
        wr(8'h1D, 8'h00);
        rd(8'h1D, 8'h00);
        main_mv = 16'h0CE4;
        settle;
        $display("end of test: power on");
        for (int s = 0; s < 4; s++) begin
            wr(8'h1F, {s[1:0], 6'h20});
            repeat (PM) @(negedge clk);
            cnt(PM, s == 0 ? W0 : s == 1 ? W1 : s == 2 ? W2 : W3);
        end
        wr(8'h1F, 8'h20);
        $display("end of test: windows");
        backup_mv = 16'h0BEA;
        repeat (2 * PM + 10) @(negedge clk);
        rd(8'h1D, 8'h01);
        wait_idle;
        chk({switch_two, switch_one}, 8'h01);
        wr(8'h1D, 8'h00);
        rd(8'h1D, 8'h01);
        wr(8'h1F, 8'h21);
        repeat (2 * PM + 10) @(negedge clk);
        rd(8'h1D, 8'h00);
        wait_idle;
        chk({switch_two, switch_one}, 8'h03);
        wr(8'h1F, 8'h23);
        repeat (2 * PM + 10) @(negedge clk);
        wait_idle;
        chk({fsel, stop_off, switch_two, switch_one}, 8'h1F);
        wr(8'h1F, 8'h22);
        repeat (2 * PM + 10) @(negedge clk);
        rd(8'h1D, 8'h01);
        wr(8'h1F, 8'h20);
        backup_mv = 16'h08FC;
        repeat (2 * PM + 10) @(negedge clk);
        rd(8'h1D, 8'h80);
        wr(8'h1D, 8'h80);
        rd(8'h1D, 8'h80);
        backup_mv = 16'h0BB8;
        settle;
        wr(8'h1D, 8'h00);
        rd(8'h1D, 8'h00);
        $display("end of test: charge flags");
        main_mv = 16'h0AA0;
        settle;
        chk({host_if_halt, rst_pin, switch_one}, 8'h01);
        rd(8'h1D, 8'h04);
        wr(8'h1F, 8'h24);
        settle;
        chk({rsel, rst_pin}, 8'h03);
        wr(8'h1D, 8'h00);
        wr(8'h1F, 8'h30);
        settle;
        chk({host_if_halt, rst_pin}, 8'h02);
        wr(8'h1F, 8'h20);
        settle;
        chk(host_if_halt, 8'h01);
        rd(8'h1F, 8'h20);
        main_mv = 16'h0CE4;
        settle;
        chk({host_if_halt, rst_pin}, 8'h01);
        $display("end of test: reset output");
        wr(8'h1F, 8'h00);
        settle;
        wait_idle;
        chk({switch_two, switch_one}, 8'h01);
        main_mv = 16'h0000;
        settle;
        wait_idle;
        chk({switch_two, switch_one}, 8'h02);
        wr(8'h1F, 8'hC0);
        repeat (PB) @(negedge clk);
        cnt(PB, W1);
        cnt(2 * PB, 8'h10);
        $display("end of test: backup operation");
        tally_and_finish;
    end
endmodule
